// *** src/alu_with_status_flags.sv ***
// Eight-bit arithmetic unit with status flags, multiplier and APB access.
`timescale 1ns/1ns

// Notes on behaviour
// - Operands are 8 bits and the unit adds, subtracts, shifts and does Boolean logic by opcode.
// - Arithmetic operands and results are handled as two's complement bytes.
// - An 8-bit working accumulator is combined with any data-memory file register as operands.
// - A move operation copies one file register to another without using the accumulator.
// - Program counter, accumulator and all special registers sit in data memory as operands.
// - Each operation updates its own subset of carry, nibble carry, zero and overflow flags.
// - On subtraction carry and nibble carry report the inverse of borrow out of the byte and the low nibble.
// - Overflow is set when the signed byte result leaves the range -128 to +127.
// - Overflow is formed from bit 7 of the two operands and of the result only, per byte.
// - The multiplier forms the full 16-bit unsigned product of two bytes in one cycle.
module alu_with_status_flags #(
   parameter int FILE_DEPTH = 16
) (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);

   ////////////////////////////////////////////////////////////////////////////
   // State.

   logic [7:0]  working_accumulator;
   logic [3:0]  arith_status_reg;
   logic [7:0]  pc_count;
   logic [15:0] product;
   logic [31:0] last_cmd;
   logic [7:0]  file_mem [FILE_DEPTH];

   ////////////////////////////////////////////////////////////////////////////
   // Data-memory decode shared by operations and the bus.

   function automatic logic file_hit(input logic [7:0] a);
      return (a >= alu_pkg::DM_FILE_BASE) &&
             (32'(a) < 32'(alu_pkg::DM_FILE_BASE) + FILE_DEPTH);
   endfunction

   function automatic logic dm_hit(input logic [7:0] a);
      return (a <= alu_pkg::DM_PRODH) || file_hit(a);
   endfunction

   function automatic logic [7:0] dm_read(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a == alu_pkg::DM_WORKING_ACCUMULATOR) begin
         v = working_accumulator;
      end else if (a == alu_pkg::DM_STATUS) begin
         v = {4'h0, arith_status_reg};
      end else if (a == alu_pkg::DM_PC) begin
         v = pc_count;
      end else if (a == alu_pkg::DM_PRODL) begin
         v = product[7:0];
      end else if (a == alu_pkg::DM_PRODH) begin
         v = product[15:8];
      end else if (file_hit(a)) begin
         v = file_mem[32'(a - alu_pkg::DM_FILE_BASE)];
      end
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode.

   logic            access;
   logic            is_cmd;
   logic            is_dm;
   logic [7:0]      bus_dm_addr;
   logic            op_legal;
   logic            exec;
   logic            bus_wr;
   alu_pkg::alu_op_t op;
   logic            dest_file;
   logic [7:0]      fa;
   logic [7:0]      fb;
   logic [7:0]      fa_val;

   assign access      = psel && penable;
   assign is_cmd      = (paddr == alu_pkg::OFF_CMD);
   assign bus_dm_addr = paddr[9:2];
   assign is_dm       = (paddr >= alu_pkg::OFF_DM_BASE) && (paddr <= alu_pkg::OFF_DM_LAST) &&
                        (paddr[1:0] == 2'b00) && dm_hit(bus_dm_addr);
   assign op          = alu_pkg::alu_op_t'(pwdata[alu_pkg::CMD_OP_LSB +: 5]);
   assign dest_file   = pwdata[alu_pkg::CMD_DEST];
   assign fa          = pwdata[alu_pkg::CMD_FA_LSB +: 8];
   assign fb          = pwdata[alu_pkg::CMD_FB_LSB +: 8];
   always_comb begin
      fa_val = dm_read(fa);
   end
   assign op_legal    = (pwdata[4:0] <= 5'(alu_pkg::OP_MUL)) && dm_hit(fa) &&
                        ((op != alu_pkg::OP_MOVFF) || dm_hit(fb));
   assign exec        = access && pwrite && is_cmd && pstrb[0] && op_legal;
   assign bus_wr      = access && pwrite && is_dm && pstrb[0];

   assign pready  = 1'b1;
   assign pslverr = access && !(is_dm || (is_cmd && (!pwrite || op_legal)));

   ////////////////////////////////////////////////////////////////////////////
   // Arithmetic and logic.

   logic       use_add;
   logic       do_wr;
   logic [7:0] dst;
   logic [7:0] add_b;
   logic       cin;
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] res;
   logic [3:0] flags;
   logic [3:0] mask;
   logic       carry_now;

   assign carry_now = arith_status_reg[alu_pkg::ST_C];

   always_comb begin
      use_add = 1'b0;
      do_wr   = 1'b1;
      dst     = dest_file ? fa : alu_pkg::DM_WORKING_ACCUMULATOR;
      add_b   = 8'h00;
      cin     = 1'b0;
      res     = 8'h00;
      flags   = 4'h0;
      mask    = 4'h0;
      sum     = 9'h000;
      nib     = 5'h00;
      unique case (op)
         alu_pkg::OP_ADD: begin
            use_add = 1'b1;
            add_b   = working_accumulator;
         end
         alu_pkg::OP_ADDC: begin
            use_add = 1'b1;
            add_b   = working_accumulator;
            cin     = carry_now;
         end
         alu_pkg::OP_SUB: begin
            use_add = 1'b1;
            add_b   = ~working_accumulator;
            cin     = 1'b1;
         end
         alu_pkg::OP_SUBB: begin
            use_add = 1'b1;
            add_b   = ~working_accumulator;
            cin     = carry_now;
         end
         alu_pkg::OP_INC: begin
            use_add = 1'b1;
            cin     = 1'b1;
         end
         alu_pkg::OP_DEC: begin
            use_add = 1'b1;
            add_b   = 8'hFF;
         end
         alu_pkg::OP_AND: begin
            res  = fa_val & working_accumulator;
            mask = 4'h4;
         end
         alu_pkg::OP_IOR: begin
            res  = fa_val | working_accumulator;
            mask = 4'h4;
         end
         alu_pkg::OP_XOR: begin
            res  = fa_val ^ working_accumulator;
            mask = 4'h4;
         end
         alu_pkg::OP_COM: begin
            res  = ~fa_val;
            mask = 4'h4;
         end
         alu_pkg::OP_RLC: begin
            res               = {fa_val[6:0], carry_now};
            flags[alu_pkg::ST_C] = fa_val[7];
            mask              = 4'h1;
         end
         alu_pkg::OP_RRC: begin
            res               = {carry_now, fa_val[7:1]};
            flags[alu_pkg::ST_C] = fa_val[0];
            mask              = 4'h1;
         end
         alu_pkg::OP_CLR: begin
            mask = 4'h4;
         end
         alu_pkg::OP_MOVWF: begin
            res = working_accumulator;
            dst = fa;
         end
         alu_pkg::OP_MOVFW: begin
            res  = fa_val;
            mask = 4'h4;
         end
         alu_pkg::OP_MOVFF: begin
            res = fa_val;
            dst = fb;
         end
         alu_pkg::OP_MUL: begin
            do_wr = 1'b0;
         end
         default: begin
            do_wr = 1'b0;
         end
      endcase
      if (use_add) begin
         sum  = {1'b0, fa_val} + {1'b0, add_b} + {8'h00, cin};
         nib  = {1'b0, fa_val[3:0]} + {1'b0, add_b[3:0]} + {4'h0, cin};
         res  = sum[7:0];
         mask = 4'hF;
         flags[alu_pkg::ST_C]  = sum[8];
         flags[alu_pkg::ST_DC] = nib[4];
         flags[alu_pkg::ST_OV] = (fa_val[7] == add_b[7]) && (sum[7] != fa_val[7]);
      end
      flags[alu_pkg::ST_Z] = (res == 8'h00);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Unified data-memory write port.

   logic       wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;

   assign wr_en   = (exec && do_wr) || bus_wr;
   assign wr_addr = exec ? dst : bus_dm_addr;
   assign wr_data = exec ? res : pwdata[7:0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         working_accumulator <= alu_pkg::RST_BYTE;
      end else if (wr_en && wr_addr == alu_pkg::DM_WORKING_ACCUMULATOR) begin
         working_accumulator <= wr_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arith_status_reg <= alu_pkg::RST_FLAGS;
      end else if (wr_en && wr_addr == alu_pkg::DM_STATUS) begin
         arith_status_reg <= wr_data[3:0];
      end else if (exec) begin
         arith_status_reg <= (arith_status_reg & ~mask) | (flags & mask);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_count <= alu_pkg::RST_BYTE;
      end else if (wr_en && wr_addr == alu_pkg::DM_PC) begin
         pc_count <= wr_data;
      end else if (exec) begin
         pc_count <= pc_count + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         product <= alu_pkg::RST_PROD;
      end else if (exec && op == alu_pkg::OP_MUL) begin
         product <= 16'(fa_val) * 16'(working_accumulator);
      end else if (wr_en && wr_addr == alu_pkg::DM_PRODL) begin
         product[7:0] <= wr_data;
      end else if (wr_en && wr_addr == alu_pkg::DM_PRODH) begin
         product[15:8] <= wr_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < FILE_DEPTH; i++) begin
            file_mem[i] <= alu_pkg::RST_BYTE;
         end
      end else if (wr_en && file_hit(wr_addr)) begin
         file_mem[32'(wr_addr - alu_pkg::DM_FILE_BASE)] <= wr_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_cmd <= alu_pkg::RST_CMD;
      end else if (exec) begin
         last_cmd <= pwdata & alu_pkg::CMD_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data, captured in the setup cycle.

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         if (paddr == alu_pkg::OFF_CMD) begin
            prdata <= last_cmd;
         end else if (paddr >= alu_pkg::OFF_DM_BASE && paddr <= alu_pkg::OFF_DM_LAST &&
                      paddr[1:0] == 2'b00) begin
            prdata <= {24'h000000, dm_read(paddr[9:2])};
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end

endmodule

// *** inc/alu_pkg.sv ***
// Constants and types shared by the arithmetic unit and its bench.
package alu_pkg;

   // APB byte offsets.
   localparam logic [11:0] OFF_CMD     = 12'h000;
   localparam logic [11:0] OFF_DM_BASE = 12'h400;
   localparam logic [11:0] OFF_DM_LAST = 12'h7FC;

   // Data-memory addresses of the special registers and of the file-register base.
   localparam logic [7:0] DM_WORKING_ACCUMULATOR      = 8'h00;
   localparam logic [7:0] DM_STATUS    = 8'h01;
   localparam logic [7:0] DM_PC        = 8'h02;
   localparam logic [7:0] DM_PRODL     = 8'h03;
   localparam logic [7:0] DM_PRODH     = 8'h04;
   localparam logic [7:0] DM_FILE_BASE = 8'h10;

   // Bit positions in the arithmetic status register.
   localparam int ST_C  = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z  = 2;
   localparam int ST_OV = 3;

   // Command word fields.
   localparam int CMD_OP_LSB  = 0;
   localparam int CMD_DEST    = 5;
   localparam int CMD_FA_LSB  = 8;
   localparam int CMD_FB_LSB  = 16;
   localparam logic [31:0] CMD_MASK = 32'h00FFFF3F;

   // Reset values.
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [3:0]  RST_FLAGS = 4'h0;
   localparam logic [15:0] RST_PROD = 16'h0000;
   localparam logic [31:0] RST_CMD = 32'h00000000;

   // Operations, in command-code order starting at zero.
   typedef enum logic [4:0] {
      OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_INC, OP_DEC,
      OP_AND, OP_IOR, OP_XOR, OP_COM, OP_RLC, OP_RRC,
      OP_CLR, OP_MOVWF, OP_MOVFW, OP_MOVFF, OP_MUL
   } alu_op_t;

endpackage

// *** verification/alu_checker.sv ***
// Port assertions for the arithmetic unit.
`timescale 1ns/1ns
module alu_checker #(
   parameter int FILE_DEPTH = 16
) (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   localparam logic [11:0] A_W  = alu_pkg::OFF_DM_BASE;
   localparam logic [11:0] A_ST = alu_pkg::OFF_DM_BASE + 12'h004;
   logic        acc;
   logic        mapped;
   logic [7:0]  idx;
   logic [7:0]  w_val;
   logic        w_ok;
   logic [31:0] c_val;

   assign acc = psel && penable;
   assign idx = paddr[9:2];
   assign mapped = paddr == alu_pkg::OFF_CMD || (paddr[11:10] == 2'b01 && paddr[1:0] == 2'b00
      && (idx <= alu_pkg::DM_PRODH || (idx >= alu_pkg::DM_FILE_BASE
      && idx < alu_pkg::DM_FILE_BASE + FILE_DEPTH)));

   // Shadows of the accumulator and the last accepted command.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         w_ok  <= 1'b1;
         w_val <= alu_pkg::RST_BYTE;
         c_val <= alu_pkg::RST_CMD;
      end else if (acc && pready && pwrite && !pslverr) begin
         if (paddr == A_W && pstrb[0]) begin
            w_ok  <= 1'b1;
            w_val <= pwdata[7:0];
         end
         if (paddr == alu_pkg::OFF_CMD && pstrb[0]) begin
            w_ok  <= 1'b0;
            c_val <= pwdata & alu_pkg::CMD_MASK;
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_ready; pready; endproperty
   a_ready: assert property (p_ready) else $error("pready low");
   property p_err_idle; !acc |-> !pslverr; endproperty
   a_err_idle: assert property (p_err_idle) else $error("pslverr outside access");
   property p_unmap; acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0); endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
   property p_map_rd;
      acc && !pwrite && mapped |-> !pslverr &&
         (paddr == alu_pkg::OFF_CMD ? prdata[31:24] == 8'h00 : prdata[31:8] == 24'h000000);
   endproperty
   a_map_rd: assert property (p_map_rd) else $error("mapped read wrong");
   property p_badop;
      acc && pwrite && paddr == alu_pkg::OFF_CMD && pwdata[4:0] > 5'h10 |-> pslverr;
   endproperty
   a_badop: assert property (p_badop) else $error("bad opcode accepted");
   property p_status; acc && !pwrite && paddr == A_ST |-> prdata[7:4] == 4'h0; endproperty
   a_status: assert property (p_status) else $error("status upper bits set");
   property p_wback; acc && !pwrite && paddr == A_W && w_ok |-> prdata[7:0] == w_val; endproperty
   a_wback: assert property (p_wback) else $error("accumulator readback wrong");
   property p_cmd; acc && !pwrite && paddr == alu_pkg::OFF_CMD |-> prdata == c_val; endproperty
   a_cmd: assert property (p_cmd) else $error("command readback wrong");
endmodule

bind alu_with_status_flags alu_checker #(.FILE_DEPTH(FILE_DEPTH)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr));

// *** verification/decoder_model.sv ***
// Decoder model that issues APB transfers to the unit.
`timescale 1ns/1ns
module decoder_model (
   // Clock.
   input  wire logic        pclk,
   // APB master.
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [11:0] paddr,
   output logic      [31:0] pwdata,
   output logic      [3:0]  pstrb,
   input  wire logic        pready
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
      pstrb   = 4'hF;
   end

   // One transfer, held until pready, then released with scrambled lines.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask
endmodule

// *** verification/alu_with_status_flags_test.sv ***
// Self-checking bench for the arithmetic unit.
`timescale 1ns/1ns
module alu_with_status_flags_test;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic [32:0] expq[$];
   logic [32:0] ex;
   int          n_mismatch = 0;
   int          total_checks = 0;
   logic [31:0] seed = 32'hFB0EAAFF;
   logic [3:0]  st = 4'h0;
   logic [7:0]  w, f, r;
   logic [8:0]  s;
   logic [4:0]  nib, opc;
   logic [15:0] p;

   initial forever #4 pclk = ~pclk;

   alu_with_status_flags dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   decoder_model u_dec (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready));

   ////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   function automatic logic [11:0] dm(input logic [7:0] n);
      return alu_pkg::OFF_DM_BASE + {2'b00, n, 2'b00};
   endfunction
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      u_dec.xfer(1'b1, a, {24'h0, d});
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      expq.push_back(e);
      u_dec.xfer(1'b0, a, 32'h0);
   endtask
   task automatic op(input logic [4:0] o, input logic [7:0] fa, input logic [7:0] fb);
      u_dec.xfer(1'b1, alu_pkg::OFF_CMD, {8'h00, fb, fa, 3'b001, o});
   endtask
   task automatic arith(input logic [7:0] a, input logic [7:0] b, input logic ci);
      s = a + b + ci;
      nib = a[3:0] + b[3:0] + ci;
      r = s[7:0];
      st = {(a[7] == b[7]) && (r[7] != a[7]), r == 8'h00, nib[4], s[8]};
   endtask

   // Compares each read against the oldest noted expectation.
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         ex = expq.pop_front();
         total_checks++;
         if ({pslverr, prdata} !== ex) begin
            n_mismatch++;
            $display("ERROR %0t addr %h got %h exp %h", $time, paddr, {pslverr, prdata}, ex);
         end
      end
   end

   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      #40000;
      n_mismatch++;
      $display("ERROR %0t watchdog expired", $time);
      results;
   end

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(dm(alu_pkg::DM_WORKING_ACCUMULATOR), 33'h0);
      rd(dm(alu_pkg::DM_STATUS), 33'h0);
      rd(alu_pkg::OFF_CMD, 33'h0);
      $display("test reset done");
      // Carry chains into the next ADDC; software uses only top-byte overflow.
      for (int i = 0; i < 24; i++) begin
         seed = xs(seed);
         w = (i < 2) ? 8'h01 : seed[7:0];
         f = (i == 0) ? 8'hFF : (i == 1) ? 8'h7F : seed[15:8];
         opc = 5'(i % 4);
         wr(dm(alu_pkg::DM_WORKING_ACCUMULATOR), w);
         wr(dm(alu_pkg::DM_FILE_BASE), f);
         op(opc, alu_pkg::DM_FILE_BASE, 8'h00);
         arith(f, opc[1] ? ~w : w, opc[0] ? st[0] : opc[1]);
         rd(dm(alu_pkg::DM_FILE_BASE), {25'h0, r});
         rd(dm(alu_pkg::DM_STATUS), {29'h0, st});
         op(5'(alu_pkg::OP_MUL), alu_pkg::DM_FILE_BASE, 8'h00);
         p = r * w;
         rd(dm(alu_pkg::DM_PRODL), {25'h0, p[7:0]});
         rd(dm(alu_pkg::DM_PRODH), {25'h0, p[15:8]});
      end
      $display("test arith done");
      wr(dm(alu_pkg::DM_PC), 8'h40);
      op(5'h11, alu_pkg::DM_FILE_BASE, 8'h00);
      wr(dm(alu_pkg::DM_WORKING_ACCUMULATOR), 8'hF0);
      wr(dm(alu_pkg::DM_FILE_BASE), 8'h0F);
      op(5'(alu_pkg::OP_AND), alu_pkg::DM_FILE_BASE, 8'h00);
      st[alu_pkg::ST_Z] = 1'b1;
      rd(dm(alu_pkg::DM_FILE_BASE), 33'h0);
      rd(dm(alu_pkg::DM_STATUS), {29'h0, st});
      op(5'(alu_pkg::OP_MOVFF), alu_pkg::DM_WORKING_ACCUMULATOR, 8'h11);
      rd(dm(8'h11), {25'h0, 8'hF0});
      rd(dm(alu_pkg::DM_PC), {25'h0, 8'h42});
      rd(dm(8'h20), {1'b1, 32'h0});
      $display("test moves done");
      wr(dm(alu_pkg::DM_WORKING_ACCUMULATOR), 8'h3C);
      wr(dm(alu_pkg::DM_FILE_BASE), 8'hA5);
      rd(dm(alu_pkg::DM_WORKING_ACCUMULATOR), {25'h0, 8'h3C});
      op(5'(alu_pkg::OP_XOR), alu_pkg::DM_FILE_BASE, 8'h00);
      f = 8'hA5 ^ 8'h3C;
      st[alu_pkg::ST_Z] = (f == 8'h00);
      rd(dm(alu_pkg::DM_FILE_BASE), {25'h0, f});
      op(5'(alu_pkg::OP_RLC), alu_pkg::DM_FILE_BASE, 8'h00);
      r = {f[6:0], st[alu_pkg::ST_C]};
      st[alu_pkg::ST_C] = f[7];
      rd(dm(alu_pkg::DM_FILE_BASE), {25'h0, r});
      rd(dm(alu_pkg::DM_STATUS), {29'h0, st});
      op(5'(alu_pkg::OP_RRC), alu_pkg::DM_FILE_BASE, 8'h00);
      f = {st[alu_pkg::ST_C], r[7:1]};
      st[alu_pkg::ST_C] = r[0];
      rd(dm(alu_pkg::DM_FILE_BASE), {25'h0, f});
      rd(dm(alu_pkg::DM_STATUS), {29'h0, st});
      op(5'(alu_pkg::OP_CLR), alu_pkg::DM_FILE_BASE, 8'h00);
      op(5'(alu_pkg::OP_DEC), alu_pkg::DM_FILE_BASE, 8'h00);
      arith(8'h00, 8'hFF, 1'b0);
      rd(dm(alu_pkg::DM_FILE_BASE), {25'h0, r});
      rd(dm(alu_pkg::DM_STATUS), {29'h0, st});
      op(5'(alu_pkg::OP_INC), alu_pkg::DM_FILE_BASE, 8'h00);
      arith(r, 8'h00, 1'b1);
      rd(dm(alu_pkg::DM_STATUS), {29'h0, st});
      op(5'(alu_pkg::OP_COM), alu_pkg::DM_FILE_BASE, 8'h00);
      op(5'(alu_pkg::OP_IOR), alu_pkg::DM_FILE_BASE, 8'h00);
      st[alu_pkg::ST_Z] = 1'b0;
      rd(dm(alu_pkg::DM_FILE_BASE), {25'h0, 8'hFF});
      rd(dm(alu_pkg::DM_STATUS), {29'h0, st});
      u_dec.xfer(1'b1, alu_pkg::OFF_CMD,
         {16'h0000, alu_pkg::DM_FILE_BASE, 3'b000, 5'(alu_pkg::OP_MOVFW)});
      rd(dm(alu_pkg::DM_WORKING_ACCUMULATOR), {25'h0, 8'hFF});
      op(5'(alu_pkg::OP_MOVWF), 8'h12, 8'h00);
      rd(dm(8'h12), {25'h0, 8'hFF});
      rd(alu_pkg::OFF_CMD, {9'h000, 8'h00, 8'h12, 2'b00, 1'b1, 5'(alu_pkg::OP_MOVWF)});
      $display("test logic done");
      results;
   end
endmodule
